// [verilog/hvpa_pkg.sv]
package hvpa_pkg;

  // Register byte addresses
  localparam logic [11:0] HVPA_ADDR_STATUS    = 12'h000;
  localparam logic [11:0] HVPA_ADDR_DELAY     = 12'h004;
  localparam logic [11:0] HVPA_ADDR_ACTION    = 12'h008;
  localparam logic [11:0] HVPA_ADDR_THRESHOLD = 12'h00C;
  localparam logic [11:0] HVPA_ADDR_PV        = 12'h010;
  localparam logic [11:0] HVPA_ADDR_EVENTS    = 12'h014;
  localparam logic [11:0] HVPA_ADDR_STATE     = 12'h018;

  // Status word bit positions
  localparam int HVPA_SB_FIRE    = 0;
  localparam int HVPA_SB_BYPASS  = 1;
  localparam int HVPA_SB_SHORTCY = 2;
  localparam int HVPA_SB_DRYPUMP = 3;
  localparam int HVPA_SB_BELT    = 4;
  localparam int HVPA_SB_FILTER  = 5;
  localparam int HVPA_SB_MAINMAN = 6;
  localparam int HVPA_SB_SLEEP   = 7;
  localparam int HVPA_SB_EXTMAN  = 8;
  localparam int HVPA_SB_USED    = 9;

  // Event register bit positions
  localparam int HVPA_EB_ALARM = 0;
  localparam int HVPA_EB_FAULT = 1;
  localparam int HVPA_EB_FIRE  = 2;

  // Reset values and delay limit
  localparam logic [15:0] HVPA_DELAY_RST     = 16'h01F4;  // 5.00 s in 10 ms units
  localparam logic [15:0] HVPA_DELAY_MAX     = 16'hFDE8;  // 650.00 s
  localparam logic [1:0]  HVPA_ACTION_RST    = 2'h0;
  localparam logic [15:0] HVPA_THRESHOLD_RST = 16'h0384;  // 900

  // Alarm action codes
  localparam logic [1:0] HVPA_ACT_OFF   = 2'h0;
  localparam logic [1:0] HVPA_ACT_ALARM = 2'h1;
  localparam logic [1:0] HVPA_ACT_FAULT = 2'h2;

  // Timing: delay register counts ticks of 10 ms
  localparam int HVPA_CLK_HZ      = 20000000;
  localparam int HVPA_TICK_MS     = 10;
  localparam int HVPA_TICK_CYCLES = HVPA_CLK_HZ / 1000 * HVPA_TICK_MS;

  // Drive state indicator codes
  typedef enum logic [1:0]
  {
    HVPA_ST_RUN   = 2'b00,
    HVPA_ST_FIRE  = 2'b01,
    HVPA_ST_FAULT = 2'b10
  } hvpa_state_t;

  typedef struct packed
  {
    logic ext_manual;
    logic sleep;
    logic main_manual;
    logic filter;
    logic belt;
    logic dry_pump;
    logic short_cycle;
    logic bypass;
  } hvpa_flags_t;

endpackage : hvpa_pkg

// [verilog/hvpa_top.sv]
// Operation
// (R1) Raise high alarm after PV high persists for programmed delay, default 5.00 s.
// (R2) Delay of zero disables high detection, alarm and fault.
// (R3) Action 2 also raises high fault once motor has stopped.
// (R4) Status bit 0 shows fire mode.
// (R5) Status bit 1 shows bypass mode.
// (R6) Status bit 2 shows short-cycle protection active.
// (R7) Status bit 3 shows dry pump detected.
// (R8) Status bit 4 shows broken belt detected.
// (R9) Status bit 5 shows filter maintenance alarm.
// (R10) Status bit 6 high when main controller is manual.
// (R11) Status bit 7 shows sleep mode.
// (R12) Status bit 8 high when external controller is manual.
// (R13) Fire mode is requested by holding assigned digital input low.
// (R14) Entering fire mode raises fire alarm and updates state indicator.
// (R15) Fire mode suppresses internally generated faults.
// (R16) Action 0 disables alarms, 1 alarms only, 2 alarms then fault.
// (R17) PV is high when above threshold, default 900.
// (R18) Persistence timer restarts when PV falls to or below threshold.
// (R19) Status bits 9 to 15 read zero; status writes ignored.
`timescale 1ns/100ps
module hvpa_top
  import hvpa_pkg::*;
#(
  parameter int TICK_CYCLES = HVPA_TICK_CYCLES  // Clock cycles per 10 ms delay step
)
(
  input  wire logic        clk,                   // System clock, 20 MHz
  input  wire logic        rst_n,                 // Synchronous reset, active low
  input  wire logic        hsel,                  // AHB slave select
  input  wire logic [31:0] haddr,                 // AHB address
  input  wire logic [1:0]  htrans,                // AHB transfer type
  input  wire logic        hwrite,                // AHB write
  input  wire logic [2:0]  hsize,                 // AHB size
  input  wire logic [31:0] hwdata,                // AHB write data
  input  wire logic        hready,                // AHB bus ready
  output logic      [31:0] hrdata,                // AHB read data
  output logic             hreadyout,             // AHB slave ready
  output logic             hresp,                 // AHB response, always OKAY
  input  wire logic [15:0] pv_value,              // Signed process variable
  input  wire logic        motor_stopped,         // Motor no longer spinning
  input  wire logic        assigned_digital_input,// Fire input pin, low requests
  input  wire hvpa_flags_t hvac_flags,            // Other HVAC function flags
  output logic             pv_high_alarm,         // High level alarm
  output logic             pv_high_fault,         // High level fault
  output logic             fire_entry_alarm,      // Fire mode alarm
  output hvpa_state_t      drive_state_indicator, // Operating state
  output logic      [15:0] hvac_status_word       // HVAC status word
);

  logic        fire_meta_q;
  logic        fire_sync_q;
  logic        fire_mode_q;
  logic [15:0] delay_q;
  logic [1:0]  action_q;
  logic [15:0] threshold_q;
  logic [31:0] tick_cnt_q;
  logic [15:0] hold_cnt_q;
  logic        pv_high;
  logic        det_en;
  logic        expired;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [11:0] addr_q;
  logic        addr_ok;
  logic [31:0] rdata_d;

  // Packs the flags into the status word; reserved bits stay zero
  function automatic logic [15:0] hvpa_pack(input hvpa_flags_t f, input logic fire);
    logic [15:0] w;
    w                  = 16'h0000;  // (R19)
    w[HVPA_SB_FIRE]    = fire;            // (R4)
    w[HVPA_SB_BYPASS]  = f.bypass;        // (R5)
    w[HVPA_SB_SHORTCY] = f.short_cycle;   // (R6)
    w[HVPA_SB_DRYPUMP] = f.dry_pump;      // (R7)
    w[HVPA_SB_BELT]    = f.belt;          // (R8)
    w[HVPA_SB_FILTER]  = f.filter;        // (R9)
    w[HVPA_SB_MAINMAN] = f.main_manual;   // (R10)
    w[HVPA_SB_SLEEP]   = f.sleep;         // (R11)
    w[HVPA_SB_EXTMAN]  = f.ext_manual;    // (R12)
    return w;
  endfunction : hvpa_pack

  // Fire input synchroniser and mode
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fire_meta_q <= 1'b1;
      fire_sync_q <= 1'b1;
      fire_mode_q <= 1'b0;
    end
    else
    begin
      fire_meta_q <= assigned_digital_input;
      fire_sync_q <= fire_meta_q;
      fire_mode_q <= !fire_sync_q;  // (R13)
    end
  end

  // Fire outranks fault in the state indicator
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fire_entry_alarm      <= 1'b0;
      drive_state_indicator <= HVPA_ST_RUN;
    end
    else
    begin
      fire_entry_alarm <= fire_mode_q;  // (R14)
      if (fire_mode_q)
        drive_state_indicator <= HVPA_ST_FIRE;  // (R14)
      else if (pv_high_fault)
        drive_state_indicator <= HVPA_ST_FAULT;
      else
        drive_state_indicator <= HVPA_ST_RUN;
    end
  end

  // Detection needs a nonzero delay and an enabled action
  assign pv_high = $signed(pv_value) > $signed(threshold_q);  // (R17)
  assign det_en  = (delay_q != 16'h0000) && (action_q != HVPA_ACT_OFF);  // (R2) (R16)
  assign expired = hold_cnt_q >= delay_q;

  // Persistence timer in 10 ms ticks
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tick_cnt_q <= 32'h0000_0000;
      hold_cnt_q <= 16'h0000;
    end
    else if (!pv_high || !det_en)
    begin
      tick_cnt_q <= 32'h0000_0000;  // (R18)
      hold_cnt_q <= 16'h0000;  // (R18)
    end
    else if (!expired)
    begin
      if (tick_cnt_q == 32'(TICK_CYCLES - 1))
      begin
        tick_cnt_q <= 32'h0000_0000;
        hold_cnt_q <= hold_cnt_q + 16'h0001;  // (R1)
      end
      else
        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // Alarm follows condition; fault latches until condition clears
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pv_high_alarm <= 1'b0;
      pv_high_fault <= 1'b0;
    end
    else
    begin
      pv_high_alarm <= det_en && pv_high && expired;  // (R1) (R16)
      if (!det_en || action_q != HVPA_ACT_FAULT || fire_mode_q)
        pv_high_fault <= 1'b0;  // (R15) (R2)
      else if (pv_high_alarm && motor_stopped)
        pv_high_fault <= 1'b1;  // (R3)
      else if (!pv_high_alarm)
        pv_high_fault <= 1'b0;
    end
  end

  // Status word is rebuilt from live flags every cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hvac_status_word <= 16'h0000;
    else
      hvac_status_word <= hvpa_pack(hvac_flags, fire_mode_q);
  end

  // AHB-Lite slave: zero wait states
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end
    else if (hready)
    begin
      wr_pend_q <= hsel && htrans[1] && hwrite && addr_ok;
      rd_pend_q <= hsel && htrans[1] && !hwrite;
      addr_q    <= haddr[11:0];
    end
  end

  // Upper address bits must be zero for a register hit
  assign addr_ok = haddr[31:12] == 20'h0_0000;

  // Writes land at the end of the data phase
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      delay_q     <= HVPA_DELAY_RST;
      action_q    <= HVPA_ACTION_RST;
      threshold_q <= HVPA_THRESHOLD_RST;
    end
    else if (wr_pend_q)
    begin
      unique case (addr_q)
        HVPA_ADDR_DELAY:
          delay_q <= (hwdata[15:0] > HVPA_DELAY_MAX) ? HVPA_DELAY_MAX : hwdata[15:0];
        HVPA_ADDR_ACTION:
          if (hwdata[1:0] != 2'h3)
            action_q <= hwdata[1:0];
        HVPA_ADDR_THRESHOLD:
          threshold_q <= hwdata[15:0];
        default:
          ;  // (R19)
      endcase
    end
  end

  // Read data is chosen in the address phase so it stands in the data phase
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (addr_ok)
    begin
      unique case (haddr[11:0])
        HVPA_ADDR_STATUS:    rdata_d = {16'h0000, hvac_status_word};  // (R19)
        HVPA_ADDR_DELAY:     rdata_d = {16'h0000, delay_q};
        HVPA_ADDR_ACTION:    rdata_d = {30'h0000_0000, action_q};
        HVPA_ADDR_THRESHOLD: rdata_d = {16'h0000, threshold_q};
        HVPA_ADDR_PV:        rdata_d = {16'h0000, pv_value};
        HVPA_ADDR_EVENTS:    rdata_d = {29'h0000_0000, fire_entry_alarm, pv_high_fault, pv_high_alarm};
        HVPA_ADDR_STATE:     rdata_d = {30'h0000_0000, drive_state_indicator};
        default:             rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite)
        hrdata <= rdata_d;
    end
  end

  // Bus and rule checks
  AST_STATUS_HIGH_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    hvac_status_word[15:HVPA_SB_USED] == 7'h00) else $error("reserved status bits set"); // (R19)

  AST_FIRE_BIT: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(fire_sync_q) |=> ##1 hvac_status_word[HVPA_SB_FIRE]) else $error("fire bit not set"); // (R4)

  AST_FIRE_REQ: assert property (@(posedge clk) disable iff (!rst_n)
    !fire_sync_q |=> fire_mode_q) else $error("low input did not request fire"); // (R13)

  AST_FIRE_STATE: assert property (@(posedge clk) disable iff (!rst_n) // (R14)
    fire_mode_q |=> fire_entry_alarm && drive_state_indicator == HVPA_ST_FIRE)
    else $error("fire entry not indicated");

  AST_FIRE_NO_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
    fire_mode_q |=> !pv_high_fault) else $error("fault during fire mode"); // (R15)

  AST_ZERO_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
    delay_q == 16'h0000 |=> !pv_high_alarm) else $error("alarm with zero delay"); // (R2)

  AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    !pv_high |=> hold_cnt_q == 16'h0000 && !pv_high_alarm) else $error("timer not restarted"); // (R18)

  AST_ALARM_TIMING: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pv_high_alarm) |-> $past(hold_cnt_q) >= delay_q) else $error("alarm too early"); // (R1)

  AST_FAULT_CAUSE: assert property (@(posedge clk) disable iff (!rst_n) // (R3)
    $rose(pv_high_fault) |-> $past(motor_stopped) && action_q == HVPA_ACT_FAULT)
    else $error("fault without stop or action 2");

  AST_ACTION_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    action_q == HVPA_ACT_ALARM |=> !pv_high_fault) else $error("fault with action 1"); // (R16)

  AST_STATUS_FLAGS: assert property (@(posedge clk) disable iff (!rst_n) // (R5) (R6) (R7) (R8) (R9) (R10) (R11) (R12)
    rst_n |=> hvac_status_word[HVPA_SB_EXTMAN:HVPA_SB_BYPASS] == $past(hvac_flags))
    else $error("status flags do not follow inputs");

  AST_FIRE_BIT_LOW: assert property (@(posedge clk) disable iff (!rst_n) // (R4)
    fire_sync_q |=> ##1 !hvac_status_word[HVPA_SB_FIRE])
    else $error("fire bit set outside fire mode");

  AST_FIRE_EXIT: assert property (@(posedge clk) disable iff (!rst_n) // (R14)
    !fire_mode_q |=> !fire_entry_alarm && drive_state_indicator != HVPA_ST_FIRE)
    else $error("fire shown outside fire mode");

  AST_ACTION_OFF: assert property (@(posedge clk) disable iff (!rst_n) // (R16)
    action_q == HVPA_ACT_OFF |=> !pv_high_alarm && !pv_high_fault)
    else $error("alarm or fault with action 0");

  AST_ALARM_NEEDS_HIGH: assert property (@(posedge clk) disable iff (!rst_n) // (R17)
    pv_high_alarm |-> $past(pv_high))
    else $error("alarm without high level");

  AST_FAULT_NEEDS_STOP: assert property (@(posedge clk) disable iff (!rst_n) // (R3)
    !motor_stopped && !pv_high_fault |=> !pv_high_fault)
    else $error("fault raised while motor spins");

  AST_STATE_FAULT: assert property (@(posedge clk) disable iff (!rst_n) // (R3)
    pv_high_fault && !fire_mode_q |=> drive_state_indicator == HVPA_ST_FAULT)
    else $error("fault not shown in state");

  AST_ZERO_DELAY_FAULT: assert property (@(posedge clk) disable iff (!rst_n) // (R2)
    delay_q == 16'h0000 |=> !pv_high_fault)
    else $error("fault with zero delay");

  AST_DELAY_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // (R1)
    delay_q <= HVPA_DELAY_MAX)
    else $error("delay above range");

  AST_TICK_BOUND: assert property (@(posedge clk) disable iff (!rst_n) // (R1)
    tick_cnt_q < 32'(TICK_CYCLES))
    else $error("tick counter out of range");

  AST_STATUS_WR_IGNORED: assert property (@(posedge clk) disable iff (!rst_n) // (R19)
    wr_pend_q && addr_q == HVPA_ADDR_STATUS |=> $stable(delay_q) && $stable(action_q) && $stable(threshold_q))
    else $error("status write changed a register");

  AST_READ_OKAY: assert property (@(posedge clk) disable iff (!rst_n)
    rd_pend_q |-> hreadyout && !hresp)
    else $error("read data phase not ready or not okay");

endmodule : hvpa_top

// [tb/hvpa_tb.sv]
`timescale 1ns/100ps
module tb;
  import hvpa_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] pv_value = 16'h0000;
  logic        motor_stopped = 1'b0;
  logic        fire_in_n = 1'b1;
  hvpa_flags_t hvac_flags = hvpa_flags_t'(8'h00);
  logic        pv_high_alarm;
  logic        pv_high_fault;
  logic        fire_entry_alarm;
  hvpa_state_t drive_state_indicator;
  logic [15:0] hvac_status_word;
  logic [31:0] rd;
  int          n_fail = 0;
  int          checks = 0;
  int          i;
  // Short delay step keeps the alarm run inside the cycle budget
  localparam int TB_TICK = 1000;

  always #25 clk = ~clk;
  assign hready = hreadyout;

  hvpa_top #(.TICK_CYCLES(TB_TICK)) i_hvpa_top (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pv_value(pv_value), .motor_stopped(motor_stopped),
    .assigned_digital_input(fire_in_n), .hvac_flags(hvac_flags), .pv_high_alarm(pv_high_alarm),
    .pv_high_fault(pv_high_fault), .fire_entry_alarm(fire_entry_alarm),
    .drive_state_indicator(drive_state_indicator), .hvac_status_word(hvac_status_word));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Address phase held until hready, then data phase held until hready
  task automatic ahb_xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask : ahb_xfer

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    ahb_xfer(a, 1'b0, 32'h0000_0000);
    chk(name, exp, rd);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #(50 * 20000);
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    end_sim();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    chk("state", 32'h0, {30'h0, drive_state_indicator});
    rd_chk("delay", HVPA_ADDR_DELAY, 32'h0000_01F4);
    rd_chk("action", HVPA_ADDR_ACTION, 32'h0000_0000);
    rd_chk("threshold", HVPA_ADDR_THRESHOLD, 32'h0000_0384);
    ahb_xfer(HVPA_ADDR_DELAY, 1'b1, 32'h0000_FFFF);
    rd_chk("delay_max", HVPA_ADDR_DELAY, 32'h0000_FDE8);
    $display("test reset done");

    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      hvac_flags <= hvpa_flags_t'(8'h01 << i);
      settle(3);
      chk("status", 32'h1 << (i + 1), {16'h0, hvac_status_word});
    end
    @(posedge clk);
    hvac_flags <= hvpa_flags_t'(8'hFF);
    settle(3);
    rd_chk("status_all", HVPA_ADDR_STATUS, 32'h0000_01FE);
    ahb_xfer(HVPA_ADDR_STATUS, 1'b1, 32'h0000_FFFF);
    rd_chk("status_wr", HVPA_ADDR_STATUS, 32'h0000_01FE);
    rd_chk("unmapped", 12'h040, 32'h0000_0000);
    $display("test status done");

    fire_in_n <= 1'b0;
    settle(6);
    chk("fire_alarm", 32'h1, {31'h0, fire_entry_alarm});
    chk("fire_state", {30'h0, HVPA_ST_FIRE}, {30'h0, drive_state_indicator});
    chk("fire_bit", 32'h1, {31'h0, hvac_status_word[0]});
    @(posedge clk);
    fire_in_n <= 1'b1;
    settle(6);
    chk("fire_off", 32'h0, {31'h0, hvac_status_word[0]});
    $display("test fire done");

    ahb_xfer(HVPA_ADDR_THRESHOLD, 1'b1, 32'h0000_0064);
    ahb_xfer(HVPA_ADDR_ACTION, 1'b1, 32'h0000_0002);
    ahb_xfer(HVPA_ADDR_ACTION, 1'b1, 32'h0000_0003);
    rd_chk("action3", HVPA_ADDR_ACTION, 32'h0000_0002);
    ahb_xfer(HVPA_ADDR_DELAY, 1'b1, 32'h0000_0000);
    @(posedge clk);
    pv_value <= 16'h00C8;
    settle(2000);
    chk("alarm_off0", 32'h0, {31'h0, pv_high_alarm});
    ahb_xfer(HVPA_ADDR_DELAY, 1'b1, 32'h0000_0001);
    settle(100);
    chk("alarm_early", 32'h0, {31'h0, pv_high_alarm});
    for (i = 0; i < 2 * TB_TICK && pv_high_alarm !== 1'b1; i++)
      @(posedge clk);
    @(negedge clk);
    chk("alarm_on", 32'h1, {31'h0, pv_high_alarm});
    chk("alarm_time", 32'h1, {31'h0, i >= TB_TICK - 100 && i <= TB_TICK - 96});
    chk("fault_run", 32'h0, {31'h0, pv_high_fault});
    @(posedge clk);
    motor_stopped <= 1'b1;
    settle(3);
    chk("fault_on", 32'h1, {31'h0, pv_high_fault});
    chk("fault_state", {30'h0, HVPA_ST_FAULT}, {30'h0, drive_state_indicator});
    rd_chk("events", HVPA_ADDR_EVENTS, 32'h0000_0003);
    rd_chk("state_rd", HVPA_ADDR_STATE, 32'h0000_0002);
    rd_chk("pv", HVPA_ADDR_PV, 32'h0000_00C8);
    ahb_xfer(HVPA_ADDR_ACTION, 1'b1, 32'h0000_0001);
    settle(2);
    chk("act1_alarm", 32'h1, {31'h0, pv_high_alarm});
    chk("act1_fault", 32'h0, {31'h0, pv_high_fault});
    ahb_xfer(HVPA_ADDR_ACTION, 1'b1, 32'h0000_0002);
    settle(2);
    chk("act2_fault", 32'h1, {31'h0, pv_high_fault});
    @(posedge clk);
    fire_in_n <= 1'b0;
    settle(6);
    chk("fault_fire", 32'h0, {31'h0, pv_high_fault});
    @(posedge clk);
    fire_in_n <= 1'b1;
    settle(6);
    @(posedge clk);
    pv_value <= 16'h0064;
    settle(3);
    chk("alarm_clr", 32'h0, {31'h0, pv_high_alarm});
    chk("fault_clr", 32'h0, {31'h0, pv_high_fault});
    $display("test alarm done");
    end_sim();
  end
endmodule : tb
